// ---- src/pmasi_pkg.sv ----
// pmasi_pkg: constants, modes and register map of the pma service interface
// assumes a 32-bit ahb-lite bus with one register per aligned word
package pmasi_pkg;
  typedef enum logic [1:0] {
    PMASI_DATA  = 2'b00,
    PMASI_QUIET = 2'b01,
    PMASI_ALERT = 2'b10
  } pmasi_mode_t;

  localparam int PMASI_LANES = 4;
  localparam int PMASI_WORD_W = 32;
  localparam int PMASI_CW_BITS = 1360;
  localparam int PMASI_CW_CNT_W = 11;
  // frame loss timeout in bus clocks before remote mode falls to quiet
  localparam int PMASI_FRAME_LOSS_CYC = 64;

  localparam logic [11:0] PMASI_CTRL_ADDR = 12'h000;
  localparam logic [11:0] PMASI_STAT_ADDR = 12'h004;
  localparam logic [11:0] PMASI_CNT_ADDR = 12'h008;
  localparam logic [11:0] PMASI_ID_ADDR = 12'h00c;
  // arbitrary identification value
  localparam logic [31:0] PMASI_ID_VAL = 32'h0000_5a01;

  localparam int PMASI_CTRL_EEE_BIT = 0;
  localparam int PMASI_CTRL_FORCE_FAIL_BIT = 1;
  localparam logic [31:0] PMASI_CTRL_RST = 32'h0000_0000;
endpackage : pmasi_pkg

// ---- src/pmasi_core.sv ----
// pmasi_core: pma side of the four-lane service interface with lpi signalling
// assumes client words on the same clock; pmd status pins are asynchronous
`timescale 1ns/1ps

// Function
// - each lane word goes to its framer
// - present four receive lanes with starts
// - receive lanes delivered continuously to client
// - receive status is ok or fail
// - severe error forces status fail
// - pulse update whenever status changes
// - tx mode data quiet alert, default data
// - tx mode forwarded to pmd unchanged; forced to data without deep sleep
// - quiet tx may enter low power
// - rx mode data or quiet, default data
// - rx mode forwarded to pmd unchanged; forced to data without deep sleep
// - quiet rx may enter low power
// - energy detect follows pmd signal ok
// - no energy detect without deep sleep
// - remote mode data on frames, quiet after
// - quiet plus fail-to-ok gives alert
// - pulse indication when remote mode changes
// - no remote indication without deep sleep
// - start flag begins codeword, bits 1..1360
module pmasi_core
  import pmasi_pkg::*;
#(
  parameter int WORD_W = PMASI_WORD_W,
  parameter int LOSS_CYC = PMASI_FRAME_LOSS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // transmit from client
  input wire logic [PMASI_LANES*WORD_W-1:0] tx_word,
  input wire logic [PMASI_LANES*WORD_W-1:0] tx_start,
  input wire logic tx_valid,
  // transmit to framers
  output logic [PMASI_LANES*WORD_W-1:0] frm_word,
  output logic [PMASI_LANES*WORD_W-1:0] frm_start,
  output logic frm_valid,
  output logic [PMASI_LANES*PMASI_CW_CNT_W-1:0] frm_bit_idx,
  // receive from deframer
  input wire logic [PMASI_LANES*WORD_W-1:0] dfr_word,
  input wire logic [PMASI_LANES*WORD_W-1:0] dfr_start,
  input wire logic dfr_valid,
  input wire logic dfr_frame_lock,
  input wire logic dfr_sync_err,
  // receive to client
  output logic [PMASI_LANES*WORD_W-1:0] rx_word,
  output logic [PMASI_LANES*WORD_W-1:0] rx_start,
  output logic rx_valid,
  output logic signal_ok,
  output logic signal_upd,
  // lpi modes
  input wire logic [1:0] tx_mode,
  input wire logic [1:0] rx_mode,
  output logic [1:0] pmd_tx_mode,
  output logic [1:0] pmd_rx_mode,
  output logic tx_low_power,
  output logic rx_low_power,
  // pmd status pin and derived indications
  input wire logic pmd_signal_ok,
  output logic energy_detect,
  output logic [1:0] rx_tx_mode,
  output logic rx_tx_mode_upd
);

  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic wr_pend_ff;
  logic [11:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] upd_cnt_ff;
  logic pmd_s1_ff;
  logic pmd_s2_ff;
  logic pmd_prev_ff;
  logic lock_s1_ff;
  logic lock_s2_ff;
  logic [PMASI_LANES*WORD_W-1:0] frm_word_ff;
  logic [PMASI_LANES*WORD_W-1:0] frm_start_ff;
  logic frm_valid_ff;
  logic [PMASI_LANES*PMASI_CW_CNT_W-1:0] bit_idx_ff;
  logic [PMASI_LANES*WORD_W-1:0] rx_word_ff;
  logic [PMASI_LANES*WORD_W-1:0] rx_start_ff;
  logic rx_valid_ff;
  logic sig_ok_ff;
  logic sig_upd_ff;
  logic [1:0] pmd_tx_ff;
  logic [1:0] pmd_rx_ff;
  logic ed_ff;
  pmasi_mode_t rtm_ff;
  pmasi_mode_t nxt_rtm;
  logic rtm_upd_ff;
  logic [15:0] loss_cnt_ff;
  logic [15:0] nxt_loss_cnt;

  // bus decode
  wire bus_req = hsel && hready && htrans[1];
  wire bus_wr = bus_req && hwrite;
  wire bus_rd = bus_req && !hwrite;
  wire eee_en = ctrl_ff[PMASI_CTRL_EEE_BIT];
  wire force_fail = ctrl_ff[PMASI_CTRL_FORCE_FAIL_BIT];
  wire hit_ctrl = (addr_ff == PMASI_CTRL_ADDR);
  wire wr_ctrl = wr_pend_ff && hit_ctrl;
  // reads decode the address phase so data stands through the data phase
  wire [11:0] rd_addr = haddr[11:0];
  wire rd_ctrl = (rd_addr == PMASI_CTRL_ADDR);
  wire rd_stat = (rd_addr == PMASI_STAT_ADDR);
  wire rd_cnt = (rd_addr == PMASI_CNT_ADDR);
  wire rd_id = (rd_addr == PMASI_ID_ADDR);
  wire [31:0] stat_word = {24'h00_0000, rtm_ff, ed_ff, lock_s2_ff, pmd_s2_ff, sig_ok_ff, 2'b00};
  // control read takes nxt_ctrl so a read right after a write sees the new value
  wire [31:0] rd_mux = rd_ctrl ? nxt_ctrl :
                       rd_stat ? stat_word :
                       rd_cnt ? upd_cnt_ff :
                       rd_id ? PMASI_ID_VAL : 32'h0000_0000;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = 32'h0000_0000;
      nxt_ctrl[1:0] = hwdata[1:0];
    end
  end

  // modes used; a lapsed client without deep sleep reads as data
  wire [1:0] tx_mode_eff = eee_en ? tx_mode : PMASI_DATA;
  wire [1:0] rx_mode_eff = eee_en ? rx_mode : PMASI_DATA;
  // severe errors: loss of sync or frame lock, or forced by software
  wire nxt_sig_ok = lock_s2_ff && !dfr_sync_err && !force_fail;
  wire frames_on = lock_s2_ff && dfr_valid;
  wire pmd_rise = pmd_s2_ff && !pmd_prev_ff;
  wire sig_chg = (nxt_sig_ok != sig_ok_ff);
  wire nxt_ed = eee_en && pmd_s2_ff;
  // no pulse with deep sleep off: the remote mode is then held at data
  wire rtm_chg = eee_en && (nxt_rtm != rtm_ff);

  always_comb begin
    nxt_rtm = rtm_ff;
    nxt_loss_cnt = loss_cnt_ff;
    if (frames_on) begin
      nxt_rtm = PMASI_DATA;
      nxt_loss_cnt = 16'h0000;
    end else if (rtm_ff == PMASI_QUIET && pmd_rise) begin
      nxt_rtm = PMASI_ALERT;
    end else if (rtm_ff == PMASI_DATA) begin
      // timeout avoids calling a short gap a quiet period
      if (loss_cnt_ff == 16'(LOSS_CYC - 1)) begin
        nxt_rtm = PMASI_QUIET;
        nxt_loss_cnt = 16'h0000;
      end else begin
        nxt_loss_cnt = loss_cnt_ff + 16'h0001;
      end
    end
    if (!eee_en) begin
      nxt_rtm = PMASI_DATA;
      nxt_loss_cnt = 16'h0000;
    end
  end

  // per-lane codeword bit index, restarting on a start flag
  genvar g;
  generate
    for (g = 0; g < PMASI_LANES; g++) begin : g_lane
      wire [WORD_W-1:0] st = tx_start[g*WORD_W +: WORD_W];
      logic [PMASI_CW_CNT_W-1:0] nxt_idx;
      always_comb begin
        nxt_idx = bit_idx_ff[g*PMASI_CW_CNT_W +: PMASI_CW_CNT_W];
        for (int b = 0; b < WORD_W; b++) begin
          if (st[b]) begin
            nxt_idx = PMASI_CW_CNT_W'(1);
          end else if (nxt_idx == PMASI_CW_CNT_W'(PMASI_CW_BITS)) begin
            nxt_idx = PMASI_CW_CNT_W'(1);
          end else begin
            nxt_idx = nxt_idx + PMASI_CW_CNT_W'(1);
          end
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          bit_idx_ff[g*PMASI_CW_CNT_W +: PMASI_CW_CNT_W] <= '0;
        end else if (tx_valid) begin
          bit_idx_ff[g*PMASI_CW_CNT_W +: PMASI_CW_CNT_W] <= nxt_idx;
        end
      end
    end
  endgenerate

  // bus slave, zero wait states: hreadyout never drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= bus_wr;
      addr_ff <= bus_req ? haddr[11:0] : addr_ff;
    end
  end

  // control register, written in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= PMASI_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // read data loaded at the address phase and held between reads,
  // so it stands for the whole data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else begin
      hrdata_ff <= bus_rd ? rd_mux : hrdata_ff;
    end
  end

  // valid qualifiers, one stage each way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_valid_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
    end else begin
      frm_valid_ff <= tx_valid;
      rx_valid_ff <= dfr_valid;
    end
  end

  // lane words, one stage each way; no back pressure,
  // the client and deframer stream without pauses
  generate
    for (g = 0; g < PMASI_LANES; g++) begin : g_path
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          frm_word_ff[g*WORD_W +: WORD_W] <= '0;
          frm_start_ff[g*WORD_W +: WORD_W] <= '0;
        end else begin
          frm_word_ff[g*WORD_W +: WORD_W] <= tx_word[g*WORD_W +: WORD_W];
          frm_start_ff[g*WORD_W +: WORD_W] <= tx_start[g*WORD_W +: WORD_W];
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_word_ff[g*WORD_W +: WORD_W] <= '0;
          rx_start_ff[g*WORD_W +: WORD_W] <= '0;
        end else begin
          rx_word_ff[g*WORD_W +: WORD_W] <= dfr_word[g*WORD_W +: WORD_W];
          rx_start_ff[g*WORD_W +: WORD_W] <= dfr_start[g*WORD_W +: WORD_W];
        end
      end
    end
  endgenerate

  // two flops on each asynchronous status pin before any logic reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmd_s1_ff <= 1'b0;
      pmd_s2_ff <= 1'b0;
      pmd_prev_ff <= 1'b0;
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end else begin
      pmd_s1_ff <= pmd_signal_ok;
      pmd_s2_ff <= pmd_s1_ff;
      pmd_prev_ff <= pmd_s2_ff;
      lock_s1_ff <= dfr_frame_lock;
      lock_s2_ff <= lock_s1_ff;
    end
  end

  // receive status and its change pulse;
  // the counter lets software see short drops the pulse alone would hide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_ok_ff <= 1'b0;
      sig_upd_ff <= 1'b0;
      upd_cnt_ff <= 32'h0000_0000;
    end else begin
      sig_ok_ff <= nxt_sig_ok;
      sig_upd_ff <= sig_chg;
      upd_cnt_ff <= upd_cnt_ff + 32'(sig_chg);
    end
  end

  // modes to the pmd, registered so client-side glitches never reach it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmd_tx_ff <= PMASI_DATA;
      pmd_rx_ff <= PMASI_DATA;
      ed_ff <= 1'b0;
    end else begin
      pmd_tx_ff <= tx_mode_eff;
      pmd_rx_ff <= rx_mode_eff;
      ed_ff <= nxt_ed;
    end
  end

  // inferred remote mode; costs LOSS_CYC clocks of latency into quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtm_ff <= PMASI_DATA;
      rtm_upd_ff <= 1'b0;
      loss_cnt_ff <= 16'h0000;
    end else begin
      rtm_ff <= nxt_rtm;
      rtm_upd_ff <= rtm_chg;
      loss_cnt_ff <= nxt_loss_cnt;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign frm_word = frm_word_ff;
  assign frm_start = frm_start_ff;
  assign frm_valid = frm_valid_ff;
  assign frm_bit_idx = bit_idx_ff;
  assign rx_word = rx_word_ff;
  assign rx_start = rx_start_ff;
  assign rx_valid = rx_valid_ff;
  assign signal_ok = sig_ok_ff;
  assign signal_upd = sig_upd_ff;
  assign pmd_tx_mode = pmd_tx_ff;
  assign pmd_rx_mode = pmd_rx_ff;
  assign tx_low_power = (pmd_tx_ff == PMASI_QUIET);
  assign rx_low_power = (pmd_rx_ff == PMASI_QUIET);
  assign energy_detect = ed_ff;
  assign rx_tx_mode = rtm_ff;
  assign rx_tx_mode_upd = rtm_upd_ff;
endmodule : pmasi_core

// ---- dv/pmasi_core_sva.sv ----
// assertions on pmasi_core ports
// bound below to every pmasi_core instance
`timescale 1ns/1ps
module pmasi_core_sva
  import pmasi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // lanes
  input wire logic [127:0] tx_word,
  input wire logic tx_valid,
  input wire logic [127:0] frm_word,
  input wire logic frm_valid,
  input wire logic dfr_valid,
  // status and modes
  input wire logic dfr_sync_err,
  input wire logic signal_ok,
  input wire logic signal_upd,
  input wire logic [1:0] tx_mode,
  input wire logic [1:0] pmd_tx_mode,
  input wire logic pmd_signal_ok,
  input wire logic energy_detect,
  input wire logic [1:0] rx_tx_mode,
  input wire logic rx_tx_mode_upd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_to_quiet; $changed(rx_tx_mode) && rx_tx_mode == PMASI_QUIET; endsequence
  sequence s_to_alert; $changed(rx_tx_mode) && rx_tx_mode == PMASI_ALERT; endsequence
  property p_frm; tx_valid |=> frm_valid && frm_word == $past(tx_word); endproperty
  a_frm: assert property (p_frm) else $error("lane word lost");
  property p_upd; signal_upd == $changed(signal_ok); endproperty
  a_upd: assert property (p_upd) else $error("status pulse wrong");
  property p_err; dfr_sync_err |=> !signal_ok; endproperty
  a_err: assert property (p_err) else $error("ok during error");
  property p_txf; pmd_tx_mode != PMASI_DATA |-> pmd_tx_mode == $past(tx_mode); endproperty
  a_txf: assert property (p_txf) else $error("tx mode altered");
  property p_ed; $rose(energy_detect) |-> $past(pmd_signal_ok, 3); endproperty
  a_ed: assert property (p_ed) else $error("energy without signal");
  property p_alert; s_to_alert |-> $past(rx_tx_mode) == PMASI_QUIET; endproperty
  a_alert: assert property (p_alert) else $error("alert not from quiet");
  property p_quiet; s_to_quiet |-> !$past(dfr_valid); endproperty
  a_quiet: assert property (p_quiet) else $error("quiet with frames");
  property p_mupd; rx_tx_mode_upd == $changed(rx_tx_mode); endproperty
  a_mupd: assert property (p_mupd) else $error("mode pulse wrong");
endmodule : pmasi_core_sva
bind pmasi_core pmasi_core_sva i_sva(.clk, .rst_n, .tx_word, .tx_valid, .frm_word, .frm_valid,
  .dfr_valid, .dfr_sync_err, .signal_ok, .signal_upd, .tx_mode, .pmd_tx_mode, .pmd_signal_ok,
  .energy_detect, .rx_tx_mode, .rx_tx_mode_upd);

// ---- dv/pmasi_client_bfm.sv ----
// client model: four aligned transmit lanes with codeword starts
// notes every word it sends in exp_q for the bench
`timescale 1ns/1ps
module pmasi_client_bfm (
  // clock and control
  input wire logic clk,
  input wire logic run,
  // transmit lanes
  output logic [127:0] tx_word,
  output logic [127:0] tx_start,
  output logic tx_valid
);
  logic [255:0] exp_q[$];
  logic [127:0] w;
  logic [31:0] st;
  int pos = 0;
  initial {tx_word, tx_start, tx_valid} = '0;
  always @(posedge clk) begin
    w = {$urandom, $urandom, $urandom, $urandom};
    for (int k = 0; k < 32; k++) st[k] = (pos + k) % 1360 < 40 && (pos + k) % 10 == 0;
    tx_valid <= run;
    // idle words invert so stale data never matches
    tx_word <= run ? w : ~tx_word;
    tx_start <= run ? {4{st}} : '0;
    if (run) begin
      exp_q.push_back({w, {4{st}}});
      pos = (pos + 32) % 1360;
    end
  end
endmodule : pmasi_client_bfm

// ---- dv/testbench.sv ----
// bench for pmasi_core: bus, lanes, status, low power modes
// client model sends lanes; bench plays deframer and pmd
`timescale 1ns/1ps
module testbench;
  import pmasi_pkg::*;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, run, dv;
  logic tx_valid, frm_valid, dfr_valid, dfr_frame_lock, dfr_sync_err, rx_valid;
  logic signal_ok, signal_upd, tx_low_power, rx_low_power, pmd_signal_ok;
  logic energy_detect, rx_tx_mode_upd;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, tx_mode, rx_mode, pmd_tx_mode, pmd_rx_mode, rx_tx_mode;
  logic [2:0] hsize;
  logic [127:0] tx_word, tx_start, frm_word, frm_start, dfr_word, dfr_start, rx_word, rx_start;
  logic [43:0] frm_bit_idx;
  logic [255:0] rxq[$], e;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  assign hready = hreadyout;
  pmasi_core #(.LOSS_CYC(8)) i_pmasi_core(.*);
  pmasi_client_bfm i_pmasi_client_bfm(.*);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(string n, logic [255:0] x, logic [255:0] g);
    checks_done++;
    if (x !== g) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1);
    r = hrdata;
    chk("hresp", 0, hresp);
  endtask : bus
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // deframer stand-in; expected words noted as they are driven
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
    e = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    {dfr_word, dfr_start} <= e;
    dfr_valid <= dv;
    if (dv) rxq.push_back(e);
  end
  always @(negedge clk) begin
    if (frm_valid === 1) chk("frm", i_pmasi_client_bfm.exp_q.pop_front(), {frm_word, frm_start});
    if (rx_valid === 1) chk("rx", rxq.pop_front(), {rx_word, rx_start});
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, hsize, run, dv} = '0;
    {dfr_frame_lock, dfr_sync_err, tx_mode, rx_mode, pmd_signal_ok} = '0;
    void'($urandom(92391));
    wt(8);
    rst_n <= 1;
    wt(1);
    bus(0, PMASI_CTRL_ADDR, '0);
    chk("ctrl", PMASI_CTRL_RST, r);
    bus(0, PMASI_ID_ADDR, '0);
    chk("id", PMASI_ID_VAL, r);
    bus(0, 32'h0000_0040, '0);
    chk("unmapped", '0, r);
    run <= 1;
    dv <= 1;
    dfr_frame_lock <= 1;
    wt(30);
    chk("ok", 1, signal_ok);
    bus(0, PMASI_STAT_ADDR, '0);
    chk("stat", 8'h14, r[7:0]);
    dfr_sync_err <= 1;
    wt(2);
    chk("err", 0, signal_ok);
    dfr_sync_err <= 0;
    bus(1, PMASI_CTRL_ADDR, 32'h0000_0002);
    wt(2);
    chk("force", 0, signal_ok);
    bus(1, PMASI_CTRL_ADDR, 32'h0000_0001);
    wt(2);
    bus(0, PMASI_CNT_ADDR, '0);
    chk("cnt", 5, r);
    for (int m = 0; m < 3; m++) begin
      tx_mode <= m[1:0];
      rx_mode <= m[1:0] & 2'b01;
      wt(2);
      chk("txm", m, pmd_tx_mode);
      chk("rxm", m & 1, pmd_rx_mode);
      chk("lp", {2{m == 1}}, {tx_low_power, rx_low_power});
    end
    chk("rdata", PMASI_DATA, rx_tx_mode);
    dv <= 0;
    wt(20);
    chk("rquiet", PMASI_QUIET, rx_tx_mode);
    pmd_signal_ok <= 1;
    wt(6);
    chk("ralert", PMASI_ALERT, rx_tx_mode);
    chk("ed1", 1, energy_detect);
    pmd_signal_ok <= 0;
    dv <= 1;
    wt(6);
    chk("ed0", 0, energy_detect);
    chk("rback", PMASI_DATA, rx_tx_mode);
    tx_mode <= PMASI_QUIET;
    rx_mode <= PMASI_QUIET;
    bus(1, PMASI_CTRL_ADDR, '0);
    pmd_signal_ok <= 1;
    dv <= 0;
    wt(20);
    chk("txoff", PMASI_DATA, pmd_tx_mode);
    chk("rxoff", PMASI_DATA, pmd_rx_mode);
    chk("edoff", 0, energy_detect);
    chk("roff", PMASI_DATA, rx_tx_mode);
    close_out();
  end
endmodule : testbench
